// File: rtl/csd_engine.sv
// chunked stride copy engine with its staging fifo
`timescale 1ns/1ps

module csd_fifo
  import csd_pkg::*;
#(
  parameter int WIDTH = CSD_DW,
  parameter int DEPTH = CSD_FIFO_DEPTH
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;
  if (WIDTH < 1 || DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_param
    $error("fifo width or depth unusable, depth must be a power of two");
  end

  assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign count = cnt_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_cnt = cnt_ff;
    if (flush)
    begin
      nxt_rd = '0;
      nxt_wr = '0;
      nxt_cnt = '0;
    end
    else
    begin
      if (push)
        nxt_wr = wr_ff + 1'b1;
      if (pop)
        nxt_rd = rd_ff + 1'b1;
      nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (push && !flush)
      mem_ff[wr_ff] <= in_data;
  end
  a_fifo_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_ff <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

module csd_engine
  import csd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire csd_cfg_s cfg,
  input wire logic start_req,
  input wire logic pipe_idle,
  output csd_acc_s acc,
  output logic acc_valid,
  input wire logic xlate_fault,
  input wire logic rsp_valid,
  input wire logic [CSD_DW-1:0] rsp_data,
  output csd_status_s status,
  output logic transfer_done_irq
);
  csd_state_e st_ff, nxt_st;
  csd_status_s stat_ff, nxt_stat;
  logic irq_ff, nxt_irq;
  logic [CSD_AW-1:0] sp_ff, nxt_sp, sb_ff, nxt_sb, dp_ff, nxt_dp, db_ff, nxt_db;
  logic [CSD_CW-1:0] sl_ff, nxt_sl, sc_ff, nxt_sc, dl_ff, nxt_dl, dc_ff, nxt_dc;
  logic [3:0] out_ff, nxt_out;
  logic [$clog2(CSD_FIFO_DEPTH):0] f_cnt;
  logic f_valid, f_in_ready, src_more, dst_more, rd_go, wr_go, start, fault_hit;
  logic last_wr, flush;
  logic [CSD_DW-1:0] f_data;
  assign start = start_req && st_ff == CSD_IDLE && out_ff == CSD_OUT_RST;
  assign src_more = sc_ff != '0 && sl_ff != '0;
  assign dst_more = dc_ff != '0 && dl_ff != '0;
  // only idle pipeline cycles; stores first so the fifo drains
  assign wr_go = st_ff == CSD_RUN && pipe_idle && f_valid && dst_more;
  // reads limited by free fifo slots so returning bytes never stall
  assign rd_go = st_ff == CSD_RUN && pipe_idle && !wr_go && src_more
    && (5'(f_cnt) + 5'(out_ff)) < 5'(CSD_FIFO_DEPTH);
  assign acc_valid = rd_go || wr_go;
  // remote homes and caches are reached through the address alone
  assign acc.write = wr_go;
  assign acc.vaddr = wr_go ? dp_ff : sp_ff;
  assign acc.wdata = f_data;
  // translation refuses a granted access with a fault
  assign fault_hit = acc_valid && xlate_fault;
  assign last_wr = wr_go && !xlate_fault && dl_ff == 16'h0001 && dc_ff == 16'h0001;
  assign flush = fault_hit;
  assign status = stat_ff;
  assign transfer_done_irq = irq_ff;

  csd_fifo #(.WIDTH(CSD_DW), .DEPTH(CSD_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(rsp_valid && st_ff == CSD_RUN),
    .in_ready(f_in_ready),
    .in_data(rsp_data),
    .out_valid(f_valid),
    .out_ready(wr_go && !xlate_fault),
    .out_data(f_data),
    .count(f_cnt)
  );

  // source walk
  always_comb
  begin
    nxt_sp = sp_ff;
    nxt_sb = sb_ff;
    nxt_sl = sl_ff;
    nxt_sc = sc_ff;
    if (start)
    begin
      // first chunk from start address and byte count
      nxt_sp = cfg.source_start_reg;
      nxt_sb = cfg.source_chunk_base_reg;
      nxt_sl = cfg.first_bytes;
      nxt_sc = cfg.chunk_count;
    end
    else if (fault_hit)
      nxt_sc = CSD_CNT_RST;
    else if (rd_go)
    begin
      nxt_sp = sp_ff + 32'h0000_0001;
      nxt_sl = sl_ff - 16'h0001;
      if (sl_ff == 16'h0001)
      begin
        // next chunk at base plus source stride
        nxt_sc = sc_ff - 16'h0001;
        nxt_sb = sb_ff + cfg.src_stride;
        nxt_sp = sb_ff + cfg.src_stride;
        nxt_sl = cfg.chunk_size;
      end
    end
  end

  // destination walk
  always_comb
  begin
    nxt_dp = dp_ff;
    nxt_db = db_ff;
    nxt_dl = dl_ff;
    nxt_dc = dc_ff;
    if (start)
    begin
      // first chunk from start address and byte count
      nxt_dp = cfg.dest_start_reg;
      nxt_db = cfg.dest_chunk_base_reg;
      nxt_dl = cfg.first_bytes;
      nxt_dc = cfg.chunk_count;
    end
    else if (fault_hit)
      nxt_dc = CSD_CNT_RST;
    else if (wr_go)
    begin
      nxt_dp = dp_ff + 32'h0000_0001;
      nxt_dl = dl_ff - 16'h0001;
      if (dl_ff == 16'h0001)
      begin
        // next chunk at base plus destination stride
        nxt_dc = dc_ff - 16'h0001;
        nxt_db = db_ff + cfg.dst_stride;
        nxt_dp = db_ff + cfg.dst_stride;
        nxt_dl = cfg.chunk_size;
      end
    end
  end

  // control and status
  always_comb
  begin
    nxt_st = st_ff;
    nxt_stat = stat_ff;
    nxt_irq = 1'b0;
    nxt_out = out_ff + 4'(rd_go && !xlate_fault) - 4'(rsp_valid && out_ff != '0);
    case (st_ff)
      CSD_IDLE:
      begin
        // addresses, bases and counts are taken at the request; chunk_size and strides are read from cfg live
        if (start)
        begin
          nxt_st = CSD_RUN;
          nxt_stat = '{fault: 1'b0, done: 1'b0, busy: 1'b1};
          if (cfg.chunk_count == '0 || cfg.first_bytes == '0)
          begin
            nxt_st = CSD_IDLE;
            nxt_stat = '{fault: 1'b0, done: 1'b1, busy: 1'b0};
            nxt_irq = 1'b1;
          end
        end
      end
      CSD_RUN:
      begin
        if (fault_hit)
        begin
          nxt_st = CSD_IDLE;
          nxt_stat = '{fault: 1'b1, done: 1'b0, busy: 1'b0};
        end
        // done and interrupt after the last store
        else if (last_wr)
        begin
          nxt_st = CSD_IDLE;
          nxt_stat = '{fault: 1'b0, done: 1'b1, busy: 1'b0};
          nxt_irq = 1'b1;
        end
      end
      default:
        nxt_st = CSD_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= CSD_IDLE;
      stat_ff <= CSD_ST_RST;
      irq_ff <= 1'b0;
      out_ff <= CSD_OUT_RST;
      sp_ff <= CSD_ADDR_RST;
      sb_ff <= CSD_ADDR_RST;
      dp_ff <= CSD_ADDR_RST;
      db_ff <= CSD_ADDR_RST;
      sl_ff <= CSD_CNT_RST;
      sc_ff <= CSD_CNT_RST;
      dl_ff <= CSD_CNT_RST;
      dc_ff <= CSD_CNT_RST;
    end
    else
    begin
      st_ff <= nxt_st;
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
      out_ff <= nxt_out;
      sp_ff <= nxt_sp;
      sb_ff <= nxt_sb;
      dp_ff <= nxt_dp;
      db_ff <= nxt_db;
      sl_ff <= nxt_sl;
      sc_ff <= nxt_sc;
      dl_ff <= nxt_dl;
      dc_ff <= nxt_dc;
    end
  end
  sequence s_start;
    st_ff == CSD_IDLE && start_req && out_ff == '0;
  endsequence
  sequence s_src_wrap;
    rd_go && !xlate_fault && sl_ff == 16'h0001 && sc_ff > 16'h0001;
  endsequence
  a_issue_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    acc_valid |-> pipe_idle)
    else $error("access issued in a busy pipeline cycle");
  a_start_busy: assert property (@(posedge mclk) disable iff (sys_rst)
    s_start ##0 (cfg.chunk_count != '0 && cfg.first_bytes != '0) |=> status.busy && !status.done)
    else $error("request did not raise busy");
  a_done_irq: assert property (@(posedge mclk) disable iff (sys_rst)
    transfer_done_irq |-> status.done && !status.busy ##1 !transfer_done_irq)
    else $error("interrupt without done status");
  a_last_done: assert property (@(posedge mclk) disable iff (sys_rst)
    last_wr |=> status.done && transfer_done_irq && st_ff == CSD_IDLE)
    else $error("last store did not finish transfer");
  a_src_first: assert property (@(posedge mclk) disable iff (sys_rst)
    s_start |=> sp_ff == $past(cfg.source_start_reg) && sl_ff == $past(cfg.first_bytes))
    else $error("source start not loaded");
  a_dst_first: assert property (@(posedge mclk) disable iff (sys_rst)
    s_start |=> dp_ff == $past(cfg.dest_start_reg) && dc_ff == $past(cfg.chunk_count))
    else $error("destination start not loaded");
  a_src_stride: assert property (@(posedge mclk) disable iff (sys_rst)
    s_src_wrap |=> sp_ff == $past(sb_ff) + cfg.src_stride && sl_ff == cfg.chunk_size)
    else $error("source chunk step wrong");
  a_fault_stop: assert property (@(posedge mclk) disable iff (sys_rst)
    fault_hit |=> status.fault && !status.busy && !acc_valid)
    else $error("fault did not stop the transfer");
  a_fifo_room: assert property (@(posedge mclk) disable iff (sys_rst)
    rsp_valid && st_ff == CSD_RUN |-> f_in_ready)
    else $error("read return with no fifo room");
endmodule

// File: rtl/csd_pkg.sv
// shared widths, reset values and carriers of the chunked stride copy engine
package csd_pkg;
  localparam int CSD_AW = 32;
  localparam int CSD_CW = 16;
  localparam int CSD_DW = 8;
  localparam int CSD_FIFO_DEPTH = 8;
  localparam logic [CSD_CW-1:0] CSD_CNT_RST = 16'h0000;
  localparam logic [CSD_AW-1:0] CSD_ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] CSD_OUT_RST = 4'h0;
  localparam int CSD_ST_BUSY_BIT = 0;
  localparam int CSD_ST_DONE_BIT = 1;
  localparam int CSD_ST_FAULT_BIT = 2;
  localparam logic [2:0] CSD_ST_RST = 3'h0;

  typedef struct packed {
    logic [CSD_CW-1:0] first_bytes;
    logic [CSD_CW-1:0] chunk_count;
    logic [CSD_CW-1:0] chunk_size;
    logic [CSD_AW-1:0] source_start_reg;
    logic [CSD_AW-1:0] source_chunk_base_reg;
    logic [CSD_AW-1:0] dest_start_reg;
    logic [CSD_AW-1:0] dest_chunk_base_reg;
    logic [CSD_AW-1:0] src_stride;
    logic [CSD_AW-1:0] dst_stride;
  } csd_cfg_s;

  typedef struct packed {
    logic write;
    logic [CSD_AW-1:0] vaddr;
    logic [CSD_DW-1:0] wdata;
  } csd_acc_s;

  typedef struct packed {
    logic fault;
    logic done;
    logic busy;
  } csd_status_s;

  typedef enum logic [0:0] {
    CSD_IDLE,
    CSD_RUN
  } csd_state_e;
endpackage

// File: dv/csd_pipe_model.sv
// cache pipeline, translation and memory model facing the copy engine
`timescale 1ns/1ps
module csd_pipe_model
  import csd_pkg::*;
(
  input wire logic mclk,
  input wire logic slow,
  input wire logic flt_en,
  input wire logic [CSD_AW-1:0] flt_addr,
  input wire csd_acc_s acc,
  input wire logic acc_valid,
  output logic pipe_idle,
  output logic xlate_fault,
  output logic rsp_valid,
  output logic [CSD_DW-1:0] rsp_data
);
  logic [CSD_DW-1:0] wr_mem [logic [CSD_AW-1:0]];
  logic [CSD_DW-1:0] rq [$];
  int wr_cnt = 0;
  int gap = 0;
  logic idle_ff = 1'b1;
  logic rv_ff = 1'b0;
  logic [CSD_DW-1:0] rd_ff = 8'h00;
  function automatic logic [7:0] src_byte(logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  assign xlate_fault = flt_en && acc_valid && acc.vaddr === flt_addr;
  assign pipe_idle = idle_ff;
  assign rsp_valid = rv_ff;
  assign rsp_data = rd_ff;
  // writes into one sparse memory by address, reads queue source bytes
  always @(posedge mclk)
  begin
    if (acc_valid === 1'b1 && !xlate_fault)
    begin
      if (acc.write)
      begin
        wr_mem[acc.vaddr] = acc.wdata;
        wr_cnt++;
      end
      else
        rq.push_back(src_byte(acc.vaddr));
    end
  end
  // core takes every other slot when slow
  always @(negedge mclk)
  begin
    idle_ff <= slow ? ~idle_ff : 1'b1;
    gap = gap + 1;
    if (rq.size() > 0 && gap > (slow ? 3 : 0))
    begin
      rv_ff <= 1'b1;
      rd_ff <= rq.pop_front();
      gap = 0;
    end
    else
    begin
      // idle data toggles, never stale
      rv_ff <= 1'b0;
      rd_ff <= ~rd_ff;
    end
  end
endmodule

// File: dv/testbench.sv
// self-checking bench of the chunked stride copy engine
`timescale 1ns/1ps
module testbench
  import csd_pkg::*;
  ;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  csd_cfg_s cfg = '0;
  logic start_req = 1'b0;
  logic slow = 1'b0;
  logic flt_en = 1'b0;
  logic [CSD_AW-1:0] flt_addr = '0;
  csd_acc_s acc;
  logic acc_valid;
  logic pipe_idle;
  logic xlate_fault;
  logic rsp_valid;
  logic irq;
  logic [CSD_DW-1:0] rsp_data;
  csd_status_s status;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int irqs = 0;
  int wr0 = 0;
  always #12.5 mclk = ~mclk;
  csd_engine dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .start_req(start_req),
    .pipe_idle(pipe_idle), .acc(acc), .acc_valid(acc_valid), .xlate_fault(xlate_fault),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .status(status), .transfer_done_irq(irq));
  csd_pipe_model pm (.mclk(mclk), .slow(slow), .flt_en(flt_en), .flt_addr(flt_addr),
    .acc(acc), .acc_valid(acc_valid), .pipe_idle(pipe_idle), .xlate_fault(xlate_fault),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (irq === 1'b1)
      irqs++;
    if (acc_valid === 1'b1 && pipe_idle !== 1'b1)
      check(0, 1, "access in busy slot");
    if (cyc > 20000)
    begin
      errors++;
      results();
    end
  end
  // start, refuse a repeat request when poke, wait for the end
  task automatic run(input csd_cfg_s c, input logic nb, input logic f, input logic poke);
    int i;
    int i0;
    @(negedge mclk);
    pm.wr_mem.delete();
    wr0 = pm.wr_cnt;
    cfg = c;
    @(negedge mclk);
    i0 = irqs;
    start_req = 1'b1;
    @(negedge mclk);
    start_req = 1'b0;
    check(status.busy, nb, "busy after start");
    if (poke)
    begin
      repeat (3) @(negedge mclk);
      check(status.busy, 1, "busy at repeat request");
      // repeat request while busy must be ignored
      start_req = 1'b1;
      @(negedge mclk);
      start_req = 1'b0;
    end
    i = 0;
    while (status.busy === 1'b1 && i < 5000)
    begin
      @(negedge mclk);
      i++;
    end
    repeat (2) @(negedge mclk);
    check(status.busy, 0, "busy after end");
    check(status.fault, f, "fault flag");
    check(status.done, !f, "done flag");
    check(irqs - i0, !f, "irq pulses");
  endtask
  // every written byte against its stride-placed source byte
  task automatic verify(input csd_cfg_s c);
    logic [31:0] s;
    logic [31:0] d;
    logic [31:0] n;
    int w;
    w = 0;
    for (int k = 0; k < c.chunk_count; k++)
    begin
      s = k == 0 ? c.source_start_reg : c.source_chunk_base_reg + k * c.src_stride;
      d = k == 0 ? c.dest_start_reg : c.dest_chunk_base_reg + k * c.dst_stride;
      n = k == 0 ? c.first_bytes : c.chunk_size;
      for (int b = 0; b < n; b++)
      begin
        check(pm.wr_mem[d + b], pm.src_byte(s + b), "byte");
        w++;
      end
    end
    check(pm.wr_cnt - wr0, w, "write count");
  endtask
  initial
  begin
    csd_cfg_s c;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    // 2d gather, unaligned, slow pipe, refused repeat
    slow = 1'b1;
    c = '{16'h0003, 16'h0003, 16'h0002, 32'h0000_1003, 32'h0000_1000,
      32'h0000_2001, 32'h0000_2001, 32'h0000_0010, 32'h0000_0003};
    run(c, 1'b1, 1'b0, 1'b1);
    verify(c);
    // long first chunk, negative source stride
    slow = 1'b0;
    c = '{16'h000c, 16'h0002, 16'h0005, 32'h0000_30ff, 32'h0000_3100,
      32'h0000_40fe, 32'h0000_4000, 32'hffff_fff0, 32'h0000_0020};
    run(c, 1'b1, 1'b0, 1'b0);
    verify(c);
    // zero chunks ends at once
    c.chunk_count = 16'h0000;
    run(c, 1'b0, 1'b0, 1'b0);
    verify(c);
    // empty first chunk ends at once too
    c.chunk_count = 16'h0002;
    c.first_bytes = 16'h0000;
    run(c, 1'b0, 1'b0, 1'b0);
    check(pm.wr_cnt - wr0, 0, "empty first chunk");
    // page fault mid transfer, then a clean rerun
    c = '{16'h0006, 16'h0001, 16'h0001, 32'h0000_5000, 32'h0000_5000,
      32'h0000_6000, 32'h0000_6000, 32'h0000_0000, 32'h0000_0000};
    flt_en = 1'b1;
    flt_addr = 32'h0000_5002;
    run(c, 1'b1, 1'b1, 1'b0);
    flt_en = 1'b0;
    repeat (4) @(negedge mclk);
    run(c, 1'b1, 1'b0, 1'b0);
    verify(c);
    results();
  end
endmodule
